// ==== dss_cfg.svh ====
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH
// Register word addresses (8-bit address, 16-bit data)
`define DSS_ADDR_MODE        8'h10
`define DSS_ADDR_SLOT_SEL    8'h11
`define DSS_ADDR_RATE        8'h12
`define DSS_ADDR_PD_SEL      8'h14
`define DSS_ADDR_STATUS      8'h15
`define DSS_ADDR_A_LED       8'h30
`define DSS_ADDR_A_PULSE     8'h31
`define DSS_ADDR_B_LED       8'h35
`define DSS_ADDR_B_PULSE     8'h36
`define DSS_ADDR_A_AFE       8'h39
`define DSS_ADDR_B_AFE       8'h3B
`define DSS_ADDR_FIFO        8'h60
`define DSS_ADDR_A_DATA      8'h64
`define DSS_ADDR_B_DATA      8'h65
// Field layout
`define DSS_PULSE_HI         15
`define DSS_PULSE_LO         8
`define DSS_PDA_HI           7
`define DSS_PDA_LO           4
`define DSS_PDB_HI           11
`define DSS_PDB_LO           8
// Reset values
`define DSS_RST_RATE         16'h0008
`define DSS_RST_PULSE        16'h0100
`define DSS_RST_LED          16'h0319
`define DSS_RST_AFE          16'h2209
// Mode encodings
`define DSS_MODE_STANDBY     2'h0
`define DSS_MODE_PROGRAM     2'h1
`define DSS_MODE_NORMAL      2'h2
// Photodiode routing encodings
`define DSS_PD_SPLIT         4'h5
`define DSS_PD_SUM           4'h1
// Timing
`define DSS_CLK_MHZ          200
`define DSS_BASE_US          25
`define DSS_PULSE_US         19
`define DSS_PROC_A_US        68
`define DSS_PROC_B_US        20
`define DSS_TICK_DIV         6250
`define DSS_FIFO_DEPTH       16
`endif

// ==== dss_front_model.sv ====
`timescale 1ns/10ps
// Optical front end feeding the two photodiode sample words
module dss_front_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Light levels chosen by the bench
  input  wire logic [15:0] small_val,
  input  wire logic [15:0] large_val,
  // Sample words towards the sequencer
  output logic      [15:0] small_photodiode,
  output logic      [15:0] large_photodiode
);
  // Small diode on channel 3, large diode on channel 4; the light level is steady
  // between updates, as a real diode output changes slowly against the clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      small_photodiode <= 16'h0000;
      large_photodiode <= 16'h0000;
    end else begin
      small_photodiode <= small_val;
      large_photodiode <= large_val;
    end
  end
endmodule

// ==== dss_pkg.sv ====
package dss_pkg;
  typedef enum logic [6:0] {
    DSS_IDLE   = 7'h01,
    DSS_SLOT_A = 7'h02,
    DSS_PROC_A = 7'h04,
    DSS_SLOT_B = 7'h08,
    DSS_PROC_B = 7'h10,
    DSS_WAIT   = 7'h20,
    DSS_SPARE  = 7'h40
  } dss_state_t;
endpackage

// ==== dss_seq.sv ====
`timescale 1ns/10ps
`include "dss_cfg.svh"
// Behaviour
// RQ1: Slot A then slot B, never overlapping
// RQ2: Each slot pulses, captures, processes itself
// RQ3: Separate settings and result per slot
// RQ4: Slot A lasts 25+19 per pulse us
// RQ5: Slot B lasts 25+19 per pulse us
// RQ6: Slot A processing takes 68 us
// RQ7: Slot B processing takes 20 us
// RQ8: Sixteen-bit rate field sets period
// RQ9: Host programs recommended timing words
// RQ10: Results in registers and a FIFO
// RQ11: Small diode channel 3, large 4
// RQ12: Either slot may select photodiodes
// RQ13: Host frames accesses with chip select; the register port has no chip select, only reg_wr and reg_rd strobes
// RQ14: 32 kHz tick paces the sequencer
// RQ15: Unused slot is skipped entirely
// RQ16: Standby, program and normal modes
// RQ17: Idle until next period boundary
module dss_seq #(
  parameter int TICK_DIV = `DSS_TICK_DIV
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port (word access, same clock)
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Photodiode samples from the front end (pin domain)
  input  wire logic [15:0] small_photodiode,
  input  wire logic [15:0] large_photodiode,
  // LED drive and status
  output logic             led_on,
  output logic             slot_a_active,
  output logic             slot_b_active,
  output logic             fifo_empty
);
  // Cycle counts derived from the time figures
  localparam int CYC_US   = `DSS_CLK_MHZ;
  localparam int BASE_CYC = `DSS_BASE_US * CYC_US;
  localparam int PULS_CYC = `DSS_PULSE_US * CYC_US;
  localparam int PRA_CYC  = `DSS_PROC_A_US * CYC_US;
  localparam int PRB_CYC  = `DSS_PROC_B_US * CYC_US;
  localparam int DEPTH    = `DSS_FIFO_DEPTH;

  // Registers
  logic [1:0]  mode;          // Operating mode
  logic [1:0]  slot_en;       // Bit0 slot A, bit1 slot B
  logic [15:0] rate;          // Ticks per sampling period
  logic [15:0] pd_sel;        // Input routing
  logic [15:0] a_led, a_pulse, a_afe;
  logic [15:0] b_led, b_pulse, b_afe;

  // Sequencer state
  dss_pkg::dss_state_t state, next_state;
  logic [23:0] cnt;           // Cycles remaining in current phase
  logic [12:0] div;           // Tick divider
  logic [15:0] per;           // Ticks left in period
  logic        tick;          // 32 kHz tick pulse

  // Two-stage synchronisers on the sample pins
  logic [31:0] smp_s1, smp_s2;

  // FIFO storage
  logic [15:0] fifo_mem [DEPTH];
  logic [3:0]  wp, rp;
  logic [4:0]  fcount;

  // Slot bundles
  dss_slot_if sa();
  dss_slot_if sb();

  // Sample pins are outside the clock domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smp_s1 <= 32'h0000_0000;
      smp_s2 <= 32'h0000_0000;
    end else begin
      smp_s1 <= {large_photodiode, small_photodiode};
      smp_s2 <= smp_s1;
    end
  end

  // Channel 4 carries the large diode, channel 3 the small; summing combines them
  wire [15:0] ch3 = smp_s2[15:0];                       // RQ11
  wire [15:0] ch4 = smp_s2[31:16];                      // RQ11
  wire [15:0] ch_sum = ch3 + ch4;                        // RQ11
  wire [3:0]  pd_a = pd_sel[`DSS_PDA_HI:`DSS_PDA_LO];
  wire [3:0]  pd_b = pd_sel[`DSS_PDB_HI:`DSS_PDB_LO];
  wire [15:0] samp_a = (pd_a == `DSS_PD_SUM) ? ch_sum : ch4;
  wire [15:0] samp_b = (pd_b == `DSS_PD_SUM) ? ch_sum : ch4;

  // Per-slot datapaths
  assign sa.led_cfg = a_led;                             // RQ3
  assign sa.afe_cfg = a_afe;
  assign sa.pd_sel  = pd_a;                              // RQ12
  assign sa.sample  = samp_a;
  assign sb.led_cfg = b_led;                             // RQ3
  assign sb.afe_cfg = b_afe;
  assign sb.pd_sel  = pd_b;                              // RQ12
  assign sb.sample  = samp_b;

  dss_slot_path u_path_a (
    .clk (clk),
    .rst (rst),
    .sl  (sa)
  );
  dss_slot_path u_path_b (
    .clk (clk),
    .rst (rst),
    .sl  (sb)
  );

  // Phase lengths; pulse count comes from the upper byte
  wire [7:0]  na = a_pulse[`DSS_PULSE_HI:`DSS_PULSE_LO];
  wire [7:0]  nb = b_pulse[`DSS_PULSE_HI:`DSS_PULSE_LO];
  wire [23:0] len_a = 24'(BASE_CYC) + 24'(PULS_CYC) * {16'h0000, na}; // RQ4
  wire [23:0] len_b = 24'(BASE_CYC) + 24'(PULS_CYC) * {16'h0000, nb}; // RQ5
  wire        running = (mode == `DSS_MODE_NORMAL);      // RQ16
  wire        phase_end = (cnt == 24'h000001);
  wire        boundary = tick && (per == 16'h0001);      // RQ8 RQ17

  // First phase of a period; a disabled slot is skipped
  dss_pkg::dss_state_t first_slot;
  assign first_slot = slot_en[0] ? dss_pkg::DSS_SLOT_A :
                      (slot_en[1] ? dss_pkg::DSS_SLOT_B : dss_pkg::DSS_WAIT); // RQ15

  // Capture on the last cycle of each slot, after its pulse train and base span, inside that slot
  assign sa.capture = (state == dss_pkg::DSS_SLOT_A) && phase_end; // RQ2
  assign sb.capture = (state == dss_pkg::DSS_SLOT_B) && phase_end; // RQ2

  // Pulse window inside a slot: LED on for the first half of each pulse slot
  wire [23:0] in_slot = cnt;
  wire        in_pulse = (in_slot > 24'(BASE_CYC)) &&
                         (((in_slot - 24'(BASE_CYC)) % 24'(PULS_CYC)) > 24'(PULS_CYC / 2));

  // Next-state logic: strict A -> procA -> B -> procB -> wait
  always_comb begin
    next_state = state;
    case (state)
      dss_pkg::DSS_IDLE: begin
        if (running && boundary) begin
          next_state = first_slot;                                             // RQ15
        end
      end
      dss_pkg::DSS_SLOT_A: if (phase_end) next_state = dss_pkg::DSS_PROC_A;    // RQ1
      dss_pkg::DSS_PROC_A: if (phase_end) next_state = slot_en[1] ? dss_pkg::DSS_SLOT_B
                                                                  : dss_pkg::DSS_WAIT; // RQ1 RQ15
      dss_pkg::DSS_SLOT_B: if (phase_end) next_state = dss_pkg::DSS_PROC_B;    // RQ1
      dss_pkg::DSS_PROC_B: if (phase_end) next_state = dss_pkg::DSS_WAIT;
      dss_pkg::DSS_WAIT: begin
        // Hold until the next period boundary, so each period starts on a boundary
        if (boundary) begin
          next_state = first_slot;                                             // RQ17
        end
      end
      default: next_state = dss_pkg::DSS_IDLE;
    endcase
    if (!running) begin
      next_state = dss_pkg::DSS_IDLE;                                          // RQ16
    end
  end

  // Load of the phase counter on entry
  wire        enter = (next_state != state);
  wire [23:0] load_val = (next_state == dss_pkg::DSS_SLOT_A) ? len_a :
                         (next_state == dss_pkg::DSS_PROC_A) ? 24'(PRA_CYC) :   // RQ6
                         (next_state == dss_pkg::DSS_SLOT_B) ? len_b :
                         (next_state == dss_pkg::DSS_PROC_B) ? 24'(PRB_CYC) :   // RQ7
                         24'h000000;

  // State and phase counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= dss_pkg::DSS_IDLE;
      cnt   <= 24'h000000;
    end else begin
      state <= next_state;
      cnt   <= enter ? load_val : ((cnt != 24'h000000) ? cnt - 24'h000001 : cnt);
    end
  end

  // 32 kHz tick; the divider is held at zero outside normal mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div  <= 13'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (div == 13'(TICK_DIV - 1));                // RQ14
      div  <= (!running || div == 13'(TICK_DIV - 1)) ? 13'h0000 : div + 13'h0001;
    end
  end

  // Period counter in ticks; the first boundary comes one tick after start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      per <= 16'h0001;
    end else if (!running) begin
      per <= 16'h0001;
    end else if (tick) begin
      per <= (per <= 16'h0001) ? ((rate == 16'h0000) ? 16'h0001 : rate) : per - 16'h0001; // RQ8
    end
  end

  // Processed result pushed to the FIFO at the end of processing
  wire        push_a = (state == dss_pkg::DSS_PROC_A) && phase_end;
  wire        push_b = (state == dss_pkg::DSS_PROC_B) && phase_end;
  wire        push = (push_a | push_b) && (fcount != 5'(DEPTH)); // Full drops the sample
  wire [15:0] push_data = push_a ? sa.result : sb.result;
  wire        fifo_rd = reg_rd && (reg_addr == `DSS_ADDR_FIFO) && (fcount != 5'h00);

  // FIFO pointers and storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp     <= 4'h0;
      rp     <= 4'h0;
      fcount <= 5'h00;
    end else begin
      wp     <= push ? wp + 4'h1 : wp;                   // RQ10
      rp     <= fifo_rd ? rp + 4'h1 : rp;
      fcount <= fcount + {4'h0, push} - {4'h0, fifo_rd};
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      fifo_mem[wp] <= push_data;                         // RQ10
    end
  end

  // Register writes; setting registers only change in program mode
  wire wr_ok = reg_wr && (mode == `DSS_MODE_PROGRAM);    // RQ16
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode    <= `DSS_MODE_STANDBY;
      slot_en <= 2'h3;
      rate    <= `DSS_RST_RATE;
      pd_sel  <= 16'h0000;
      a_led   <= `DSS_RST_LED;
      a_pulse <= `DSS_RST_PULSE;
      a_afe   <= `DSS_RST_AFE;
      b_led   <= `DSS_RST_LED;
      b_pulse <= `DSS_RST_PULSE;
      b_afe   <= `DSS_RST_AFE;
    end else begin
      if (reg_wr && reg_addr == `DSS_ADDR_MODE) begin
        mode <= reg_wdata[1:0];                          // RQ16
      end
      if (wr_ok) begin
        if (reg_addr == `DSS_ADDR_SLOT_SEL) begin
          slot_en <= reg_wdata[1:0];                     // RQ15
        end else if (reg_addr == `DSS_ADDR_RATE) begin
          rate <= reg_wdata;                             // RQ8
        end else if (reg_addr == `DSS_ADDR_PD_SEL) begin
          pd_sel <= reg_wdata;
        end else if (reg_addr == `DSS_ADDR_A_LED) begin
          a_led <= reg_wdata;                            // RQ3
        end else if (reg_addr == `DSS_ADDR_A_PULSE) begin
          a_pulse <= reg_wdata;
        end else if (reg_addr == `DSS_ADDR_A_AFE) begin
          a_afe <= reg_wdata;
        end else if (reg_addr == `DSS_ADDR_B_LED) begin
          b_led <= reg_wdata;                            // RQ3
        end else if (reg_addr == `DSS_ADDR_B_PULSE) begin
          b_pulse <= reg_wdata;
        end else if (reg_addr == `DSS_ADDR_B_AFE) begin
          b_afe <= reg_wdata;
        end
      end
    end
  end

  // Read decode; unmapped addresses read as zero
  wire [15:0] rd_mux =
    (reg_addr == `DSS_ADDR_MODE)     ? {14'h0000, mode} :
    (reg_addr == `DSS_ADDR_SLOT_SEL) ? {14'h0000, slot_en} :
    (reg_addr == `DSS_ADDR_RATE)     ? rate :
    (reg_addr == `DSS_ADDR_PD_SEL)   ? pd_sel :
    (reg_addr == `DSS_ADDR_STATUS)   ? {9'h000, state} :
    (reg_addr == `DSS_ADDR_A_LED)    ? a_led :
    (reg_addr == `DSS_ADDR_A_PULSE)  ? a_pulse :
    (reg_addr == `DSS_ADDR_A_AFE)    ? a_afe :
    (reg_addr == `DSS_ADDR_B_LED)    ? b_led :
    (reg_addr == `DSS_ADDR_B_PULSE)  ? b_pulse :
    (reg_addr == `DSS_ADDR_B_AFE)    ? b_afe :
    (reg_addr == `DSS_ADDR_FIFO)     ? ((fcount != 5'h00) ? fifo_mem[rp] : 16'h0000) :
    (reg_addr == `DSS_ADDR_A_DATA)   ? sa.result :       // RQ10
    (reg_addr == `DSS_ADDR_B_DATA)   ? sb.result :       // RQ10
    16'h0000;

  // Registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata     <= 16'h0000;
      led_on        <= 1'b0;
      slot_a_active <= 1'b0;
      slot_b_active <= 1'b0;
      fifo_empty    <= 1'b1;
    end else begin
      reg_rdata     <= reg_rd ? rd_mux : 16'h0000;
      led_on        <= ((state == dss_pkg::DSS_SLOT_A) || (state == dss_pkg::DSS_SLOT_B)) && in_pulse; // RQ2
      slot_a_active <= (state == dss_pkg::DSS_SLOT_A);   // RQ1
      slot_b_active <= (state == dss_pkg::DSS_SLOT_B);   // RQ1
      fifo_empty    <= (fcount == 5'h00) || (fcount == 5'h01 && fifo_rd && !push);
    end
  end
endmodule

// ==== dss_seq_sva.sv ====
`timescale 1ns/10ps
`include "dss_cfg.svh"
// Timing checker beside the sequencer pins
module dss_seq_sva #(
  parameter int TICK_DIV = `DSS_TICK_DIV
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] small_photodiode,
  input wire logic [15:0] large_photodiode,
  input wire logic        led_on,
  input wire logic        slot_a_active,
  input wire logic        slot_b_active,
  input wire logic        fifo_empty
);
  localparam int PROC_A_CYC = `DSS_PROC_A_US * `DSS_CLK_MHZ; // Slot A processing span
  localparam int PROC_B_CYC = `DSS_PROC_B_US * `DSS_CLK_MHZ; // Slot B processing span
  int   a_cnt;  // Length of the current slot A run
  int   b_cnt;  // Length of the current slot B run
  int   gap;    // Cycles with neither slot active
  logic last_a; // Slot A ended and slot B has not yet begun
  logic last_b; // Slot B ended and slot A has not yet begun
  // Length must be the base span plus a whole number of pulse spans
  function automatic logic len_ok(input int n);
    return (n % 200 == 0) && (n >= 5000) && ((n / 200 - 25) % 19 == 0);
  endfunction
  // Run and gap counters; the gap is cleared by either slot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_cnt  <= 0;
      b_cnt  <= 0;
      gap    <= 0;
      last_a <= 1'b0;
      last_b <= 1'b0;
    end else begin
      a_cnt  <= slot_a_active ? a_cnt + 1 : 0;
      b_cnt  <= slot_b_active ? b_cnt + 1 : 0;
      gap    <= (slot_a_active || slot_b_active) ? 0 : gap + 1;
      last_a <= $fell(slot_a_active) ? 1'b1 : ($rose(slot_b_active) ? 1'b0 : last_a);
      last_b <= $fell(slot_b_active) ? 1'b1 : ($rose(slot_a_active) ? 1'b0 : last_b);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_no_overlap: assert property (!(slot_a_active && slot_b_active))
    else $error("both slots active together");
  a_slot_a_len: assert property ($fell(slot_a_active) |-> len_ok(a_cnt))
    else $error("slot a length not base plus pulses");
  a_slot_b_len: assert property ($fell(slot_b_active) |-> len_ok(b_cnt))
    else $error("slot b length not base plus pulses");
  a_proc_a_gap: assert property ($rose(slot_b_active) && last_a |-> gap == PROC_A_CYC)
    else $error("slot a processing span wrong");
  a_proc_b_gap: assert property ($rose(slot_a_active) && last_b |-> gap >= PROC_B_CYC)
    else $error("slot b processing span too short");
  a_led_in_slot: assert property (led_on |-> (slot_a_active || slot_b_active))
    else $error("led on outside a slot");
  a_fifo_filled: assert property ($rose(slot_b_active) && last_a |-> ##[0:4] !fifo_empty)
    else $error("slot a result not queued");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  c_both_slots: cover property ($rose(slot_b_active) && last_a);
  c_b_only: cover property ($rose(slot_b_active) && !last_a);
  c_fifo_data: cover property ($fell(fifo_empty));
  c_led_pulse: cover property ($rose(led_on));
endmodule
bind dss_seq dss_seq_sva #(.TICK_DIV(TICK_DIV)) i_sva (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .small_photodiode(small_photodiode),
  .large_photodiode(large_photodiode), .led_on(led_on), .slot_a_active(slot_a_active),
  .slot_b_active(slot_b_active), .fifo_empty(fifo_empty));

// ==== dss_slot_if.sv ====
`timescale 1ns/10ps
// Per-slot settings and result travelling to the slot datapath
interface dss_slot_if;
  logic [15:0] led_cfg;   // LED timing word
  logic [15:0] afe_cfg;   // Front-end timing word
  logic [3:0]  pd_sel;    // Input routing
  logic [15:0] sample;    // Raw sample input
  logic        capture;   // Capture strobe
  logic [15:0] result;    // Processed result
  modport seq (output led_cfg, output afe_cfg, output pd_sel, output sample, output capture, input result);
  modport path (input led_cfg, input afe_cfg, input pd_sel, input sample, input capture, output result);
endinterface

// ==== dss_slot_path.sv ====
`timescale 1ns/10ps
`include "dss_cfg.svh"
// One slot datapath: owns its own captured result
module dss_slot_path (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Slot bundle
  dss_slot_if.path sl
);
  // Which photodiode sum reaches the measured channel
  wire        split = (sl.pd_sel == `DSS_PD_SPLIT);
  wire        summed = (sl.pd_sel == `DSS_PD_SUM);
  wire [15:0] routed = (split | summed) ? sl.sample : 16'h0000;
  // Result register: only this slot's capture touches it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sl.result <= 16'h0000;
    end else if (sl.capture) begin
      sl.result <= routed; // RQ3 RQ12
    end
  end
endmodule

// ==== dual_slot_sample_sequencer_bench.sv ====
`timescale 1ns/10ps
`include "dss_cfg.svh"
// Self-checking bench for the two-slot sequencer
module dual_slot_sample_sequencer_bench;
  localparam int TDIV = 10; // Short tick keeps the run brief
  logic        clk, rst, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, sv, lv, d;
  wire  [15:0] small_photodiode, large_photodiode;
  logic        led_on, slot_a_active, slot_b_active, fifo_empty;
  int          n_mismatch, checks_done, la, gab, lb, per, a_hi, hb, nl;
  logic [7:0]  ra [7] = '{8'h12, 8'h30, 8'h31, 8'h35, 8'h36, 8'h39, 8'h3B}; // Reset table addresses
  logic [15:0] rv [7] = '{16'h0008, 16'h0319, 16'h0100, 16'h0319, 16'h0100, 16'h2209, 16'h2209};
  dss_seq #(.TICK_DIV(TDIV)) i_dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .small_photodiode(small_photodiode),
    .large_photodiode(large_photodiode), .led_on(led_on), .slot_a_active(slot_a_active),
    .slot_b_active(slot_b_active), .fifo_empty(fifo_empty));
  dss_front_model i_front (.clk(clk), .rst(rst), .small_val(sv), .large_val(lv),
    .small_photodiode(small_photodiode), .large_photodiode(large_photodiode));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Slot A activity tally, to prove a disabled slot stays silent
  always @(posedge clk) if (slot_a_active) a_hi++;
  function automatic int slot_len(input int n);
    return (`DSS_BASE_US + `DSS_PULSE_US * n) * `DSS_CLK_MHZ;
  endfunction
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_count(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      n_mismatch++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Read strobe; data is registered on the same edge that takes the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk_word(what, exp, reg_rdata);
  endtask
  task automatic end_of_test;
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs about 85000 cycles
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    $display("Error watchdog expected finish seen timeout");
    end_of_test;
  end
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, n_mismatch, checks_done, a_hi} = '0;
    rst = 1'b1;
    void'($urandom(32'hef81));
    sv = {1'b0, 15'($urandom)}; // Top bit clear so the summed channel cannot wrap
    lv = {1'b0, 15'($urandom)};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i], "reset value");
    $display("test reset values done");
    wr(`DSS_ADDR_MODE, 16'h0001);
    wr(`DSS_ADDR_A_LED, 16'h0319);
    wr(`DSS_ADDR_B_LED, 16'h0319);
    wr(`DSS_ADDR_RATE, 16'h0E10);
    wr(`DSS_ADDR_PD_SEL, 16'h0150);
    wr(`DSS_ADDR_MODE, 16'h0002);
    wr(`DSS_ADDR_A_PULSE, 16'h0700);
    rd_chk(`DSS_ADDR_A_PULSE, 16'h0100, "locked pulse count");
    // Measure slot spans and the full period from one slot A start to the next
    while (!slot_a_active) step;
    {la, gab, lb, per, nl} = '0;
    while (slot_a_active) begin la++; per++; nl += int'(led_on); step; end
    while (!slot_b_active) begin gab++; per++; step; end
    while (slot_b_active) begin lb++; per++; step; end
    while (!slot_a_active) begin per++; step; end
    chk_count("slot a length", slot_len(1), la);
    chk_count("slot a led pulsed", 1, int'(nl > 0));
    chk_count("a to b gap", `DSS_PROC_A_US * `DSS_CLK_MHZ, gab);
    chk_count("slot b length", slot_len(1), lb);
    chk_count("period", 3600 * TDIV, per);
    $display("test slot timing done");
    // Second period runs out, then both data paths and the queue are inspected
    while (!slot_b_active) step;
    while (slot_b_active) step;
    repeat (`DSS_PROC_B_US * `DSS_CLK_MHZ + 8) step;
    rd_chk(`DSS_ADDR_A_DATA, lv, "slot a data");
    rd_chk(`DSS_ADDR_B_DATA, sv + lv, "slot b data");
    for (int i = 0; i < 4; i++) rd_chk(`DSS_ADDR_FIFO, i[0] ? sv + lv : lv, "queued result");
    chk_word("queue empty flag", 16'h0001, {15'h0000, fifo_empty});
    rd_chk(`DSS_ADDR_FIFO, 16'h0000, "empty pop");
    $display("test results done");
    // Slot B alone; slot A keeps its old result
    wr(`DSS_ADDR_MODE, 16'h0001);
    wr(`DSS_ADDR_SLOT_SEL, 16'h0002);
    d = lv;
    sv <= {1'b0, 15'($urandom)};
    lv <= {1'b0, 15'($urandom)};
    wr(`DSS_ADDR_MODE, 16'h0002);
    hb = a_hi;
    lb = 0;
    while (!slot_b_active) step;
    while (slot_b_active) begin lb++; step; end
    repeat (`DSS_PROC_B_US * `DSS_CLK_MHZ + 8) step;
    chk_count("slot b alone length", slot_len(1), lb);
    chk_count("slot a activity", hb, a_hi);
    rd_chk(`DSS_ADDR_B_DATA, sv + lv, "slot b new data");
    rd_chk(`DSS_ADDR_A_DATA, d, "slot a kept data");
    $display("test single slot done");
    end_of_test;
  end
endmodule
